// ==== hw/csaa_pkg.sv ====
//----------------------------------------------------------------------
// Shared constants and types for the coordinate store and ALU
//----------------------------------------------------------------------
package csaa_pkg;

  // Instruction numbers handled by this block
  localparam logic [7:0] SET_COORDINATE_CMD     = 8'h1e;
  localparam logic [7:0] GET_COORDINATE_CMD     = 8'h1f;
  localparam logic [7:0] CAPTURE_COORDINATE_CMD = 8'h20;
  localparam logic [7:0] X_REGISTER_CALC_CMD    = 8'h21;
  localparam logic [7:0] ACCU_TO_COORDINATE_CMD = 8'h27;

  // Motor field values
  localparam logic [7:0] AXIS_MOTOR = 8'h00;
  localparam logic [7:0] NV_MOTOR   = 8'hff;

  // Highest coordinate entry of the axis
  localparam int COORD_MAX = 20;

  // Reply status codes
  localparam logic [7:0] STAT_OK        = 8'h64;
  localparam logic [7:0] STAT_BAD_CSUM  = 8'h01;
  localparam logic [7:0] STAT_BAD_CMD   = 8'h02;
  localparam logic [7:0] STAT_BAD_TYPE  = 8'h03;
  localparam logic [7:0] STAT_BAD_VALUE = 8'h04;

  // X register operations (type field)
  localparam logic [3:0] CALC_ADD  = 4'h0;
  localparam logic [3:0] CALC_SUB  = 4'h1;
  localparam logic [3:0] CALC_MUL  = 4'h2;
  localparam logic [3:0] CALC_DIV  = 4'h3;
  localparam logic [3:0] CALC_MOD  = 4'h4;
  localparam logic [3:0] CALC_AND  = 4'h5;
  localparam logic [3:0] CALC_OR   = 4'h6;
  localparam logic [3:0] CALC_XOR  = 4'h7;
  localparam logic [3:0] CALC_NOT  = 4'h8;
  localparam logic [3:0] CALC_LOAD = 4'h9;
  localparam logic [3:0] CALC_SWAP = 4'ha;

  // Values after reset
  localparam logic [31:0] ACCU_RST  = 32'h0000_0000;
  localparam logic [31:0] X_RST     = 32'h0000_0000;
  localparam logic [31:0] COORD_RST = 32'h0000_0000;

  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  instr;
    logic [7:0]  typ;
    logic [7:0]  motor;
    logic [31:0] value;
    logic [7:0]  csum;
  } csaa_cmd_t;

  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  instr;
    logic [31:0] value;
  } csaa_rsp_t;

  typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_EXEC, ST_BULK, ST_REPLY} csaa_state_t;

  // Modulo-256 sum of all bytes ahead of the checksum
  function automatic logic [7:0] frame_sum(input csaa_cmd_t c);
    frame_sum = c.addr + c.instr + c.typ + c.motor + c.value[31:24]
              + c.value[23:16] + c.value[15:8] + c.value[7:0];
  endfunction : frame_sum

endpackage : csaa_pkg

// ==== hw/csaa_alu.sv ====
`timescale 1ns/1ps
`default_nettype none
// Accumulator / X register arithmetic, purely combinational
module csaa_alu (
  input  wire logic [3:0]  op,
  input  wire logic [31:0] accu,
  input  wire logic [31:0] x_in,
  output logic      [31:0] accu_out,
  output logic      [31:0] x_out,
  output logic             div_zero
);

  logic signed [31:0] a_s;
  logic signed [31:0] x_s;
  logic        [31:0] prod;

  assign a_s  = accu;
  assign x_s  = x_in;
  assign prod = 32'(a_s * x_s);

  // Accumulator is first operand, X register second
  always_comb
  begin
    accu_out = accu;
    x_out    = x_in;
    div_zero = 1'b0;
    case (op)
      csaa_pkg::CALC_ADD:  accu_out = 32'(a_s + x_s);
      csaa_pkg::CALC_SUB:  accu_out = 32'(a_s - x_s);
      csaa_pkg::CALC_MUL:  accu_out = prod;
      csaa_pkg::CALC_DIV:
      begin
        // Divide by zero keeps the accumulator, flagged instead
        div_zero = (x_in == 32'h0000_0000);
        if (!div_zero)
          accu_out = 32'(a_s / x_s);
      end
      csaa_pkg::CALC_MOD:
      begin
        div_zero = (x_in == 32'h0000_0000);
        if (!div_zero)
          accu_out = 32'(a_s % x_s);
      end
      csaa_pkg::CALC_AND:  accu_out = accu & x_in;
      csaa_pkg::CALC_OR:   accu_out = accu | x_in;
      csaa_pkg::CALC_XOR:  accu_out = accu ^ x_in;
      csaa_pkg::CALC_NOT:  x_out    = ~x_in;
      csaa_pkg::CALC_LOAD: x_out    = accu;
      csaa_pkg::CALC_SWAP:
      begin
        accu_out = x_in;
        x_out    = accu;
      end
      default: accu_out = accu;
    endcase
  end

endmodule : csaa_alu
`default_nettype wire

// ==== hw/csaa_nv_store.sv ====
`timescale 1ns/1ps
`default_nettype none
// Backing store for coordinates; entry zero is never kept here
module csaa_nv_store #(
  parameter int NUM_COORD = csaa_pkg::COORD_MAX,
  parameter int IW        = 5
) (
  input  wire logic          ref_clk,
  input  wire logic          ce,
  input  wire logic          wr_en,
  input  wire logic [IW-1:0] wr_idx,
  input  wire logic [31:0]   wr_data,
  input  wire logic [IW-1:0] rd_idx,
  output logic      [31:0]   rd_data
);

  // No reset: contents must survive the block's own reset
  logic [31:0] mem [1:NUM_COORD];

  // Writes to entry zero or beyond the array are dropped
  always_ff @(posedge ref_clk)
  begin
    if (ce && wr_en && wr_idx != '0 && int'(wr_idx) <= NUM_COORD)
      mem[wr_idx] <= wr_data;
  end

  // Read is combinational; entry zero reads as zero
  always_comb
  begin
    rd_data = csaa_pkg::COORD_RST;
    if (rd_idx != '0 && int'(rd_idx) <= NUM_COORD)
      rd_data = mem[rd_idx];
  end

endmodule : csaa_nv_store
`default_nettype wire

// ==== hw/csaa_core.sv ====
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - In a stored program, get-coordinate loads the entry into the accumulator.
// - Direct get-coordinate replies OK with the entry, accumulator untouched.
// - Persistence input picks RAM only or also backing store; RAM only by default.
// - Entry zero is never written to the backing store.
// - Get-coordinate 0 with motor 255 reloads entries 1..20 from backing store.
// - Get-coordinate n with motor 255 reloads only entry n; n is 1..20.
// - Capture-coordinate writes the actual axis position into the entry.
// - Direct capture replies OK with the captured position as value.
// - Accu-to-coordinate writes the accumulator into the entry; replies OK.
// - X calc uses accumulator and X register, result to accumulator; to X for types 8, 9; to both for type 10.
// - Types 0..4 add, subtract, multiply, divide, modulo by X.
// - Types 5..7 AND, OR, XOR with X; type 8 inverts X.
// - Type 9 copies accumulator to X; type 10 swaps them.
// - Set-coordinate stores its 32-bit value into the entry.
// - Set-coordinate with motor 255 saves entry n, or entries 1..20 for n 0.
module csaa_core #(
  parameter int NUM_COORD = csaa_pkg::COORD_MAX
) (
  input  wire logic                ref_clk,
  input  wire logic                reset,
  input  wire logic                ce,
  input  wire logic                cmd_valid,
  output logic                     cmd_ready,
  input  wire logic                cmd_direct,
  input  wire csaa_pkg::csaa_cmd_t cmd,
  output logic                     rsp_valid,
  input  wire logic                rsp_ready,
  output csaa_pkg::csaa_rsp_t      rsp,
  input  wire logic [31:0]         actual_pos,
  input  wire logic                nv_persist_en,
  output logic      [31:0]         accu,
  output logic      [31:0]         x_reg
);

  localparam int IW = $clog2(NUM_COORD + 1);
  localparam logic [IW-1:0] LAST_IDX = IW'(NUM_COORD);
  localparam logic [IW-1:0] FIRST_IDX = IW'(1);

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  csaa_pkg::csaa_state_t state_r;
  csaa_pkg::csaa_state_t state_nxt;
  csaa_pkg::csaa_cmd_t   cmd_r;
  csaa_pkg::csaa_rsp_t   rsp_r;
  logic                  direct_r;
  logic                  boot_r;
  logic                  bulk_load_r;
  logic [IW-1:0]         bulk_idx_r;
  logic [31:0]           accu_r;
  logic [31:0]           x_r;
  logic [31:0]           coord_r [0:NUM_COORD];

  logic [IW-1:0] coord_idx;
  logic          coord_ok;
  logic          is_nv;
  logic          csum_ok;
  logic [7:0]    status_c;
  logic          exec_ok;
  logic          bulk_go;
  logic [31:0]   rd_coord;
  logic [31:0]   alu_accu;
  logic [31:0]   alu_x;
  logic          alu_div0;
  logic          ram_we;
  logic [IW-1:0] ram_widx;
  logic [31:0]   ram_wdata;
  logic          nv_we;
  logic [IW-1:0] nv_widx;
  logic [31:0]   nv_wdata;
  logic [IW-1:0] nv_ridx;
  logic [31:0]   nv_rd_data;

  //--------------------------------------------------------------------
  // Decode
  //--------------------------------------------------------------------
  // Entry index from the type field; a type beyond the array selects entry zero
  assign coord_ok  = cmd_r.typ <= 8'(NUM_COORD);
  assign coord_idx = coord_ok ? cmd_r.typ[IW-1:0] : '0;
  assign is_nv     = cmd_r.motor == csaa_pkg::NV_MOTOR;
  assign rd_coord  = coord_r[coord_idx];
  // Stored programs carry no checksum, so only host frames are checked
  assign csum_ok   = !direct_r || cmd_r.csum == csaa_pkg::frame_sum(cmd_r);

  // Status of the latched command
  always_comb
  begin
    status_c = csaa_pkg::STAT_OK;
    if (!csum_ok)
      status_c = csaa_pkg::STAT_BAD_CSUM;
    else
      case (cmd_r.instr)
        csaa_pkg::SET_COORDINATE_CMD, csaa_pkg::GET_COORDINATE_CMD:
          if (!coord_ok || !(is_nv || cmd_r.motor == csaa_pkg::AXIS_MOTOR))
            status_c = csaa_pkg::STAT_BAD_VALUE;
        csaa_pkg::CAPTURE_COORDINATE_CMD, csaa_pkg::ACCU_TO_COORDINATE_CMD:
          if (!coord_ok || cmd_r.motor != csaa_pkg::AXIS_MOTOR)
            status_c = csaa_pkg::STAT_BAD_VALUE;
        csaa_pkg::X_REGISTER_CALC_CMD:
          if (cmd_r.typ > 8'(csaa_pkg::CALC_SWAP))
            status_c = csaa_pkg::STAT_BAD_TYPE;
          else if (alu_div0)
            status_c = csaa_pkg::STAT_BAD_VALUE;
        default: status_c = csaa_pkg::STAT_BAD_CMD;
      endcase
  end

  assign exec_ok = state_r == csaa_pkg::ST_EXEC && status_c == csaa_pkg::STAT_OK;
  // Whole-array copy: type 0 with motor 255
  assign bulk_go = exec_ok && is_nv && coord_idx == '0
                && (cmd_r.instr == csaa_pkg::GET_COORDINATE_CMD
                 || cmd_r.instr == csaa_pkg::SET_COORDINATE_CMD);

  //--------------------------------------------------------------------
  // Arithmetic unit and backing store
  //--------------------------------------------------------------------
  csaa_alu u_alu (
    .op       (cmd_r.typ[3:0]),
    .accu     (accu_r),
    .x_in     (x_r),
    .accu_out (alu_accu),
    .x_out    (alu_x),
    .div_zero (alu_div0)
  );

  csaa_nv_store #(.NUM_COORD(NUM_COORD), .IW(IW)) u_nv (
    .ref_clk (ref_clk),
    .ce      (ce),
    .wr_en   (nv_we),
    .wr_idx  (nv_widx),
    .wr_data (nv_wdata),
    .rd_idx  (nv_ridx),
    .rd_data (nv_rd_data)
  );

  assign nv_ridx = state_r == csaa_pkg::ST_BULK ? bulk_idx_r : coord_idx;

  //--------------------------------------------------------------------
  // Array write paths
  //--------------------------------------------------------------------
  // Volatile array writes; backing store mirrors them when persistence is on
  always_comb
  begin
    ram_we    = 1'b0;
    ram_widx  = coord_idx;
    ram_wdata = cmd_r.value;
    nv_we     = 1'b0;
    nv_widx   = coord_idx;
    nv_wdata  = rd_coord;
    if (state_r == csaa_pkg::ST_BULK)
    begin
      ram_widx  = bulk_idx_r;
      ram_wdata = nv_rd_data;
      nv_widx   = bulk_idx_r;
      nv_wdata  = coord_r[bulk_idx_r];
      ram_we    = bulk_load_r;
      nv_we     = !bulk_load_r;
    end
    else if (exec_ok && !bulk_go)
      case (cmd_r.instr)
        csaa_pkg::SET_COORDINATE_CMD:
        begin
          ram_we   = !is_nv;
          nv_we    = is_nv || nv_persist_en;
          nv_wdata = is_nv ? rd_coord : cmd_r.value;
        end
        csaa_pkg::GET_COORDINATE_CMD:
        begin
          ram_we    = is_nv;
          ram_wdata = nv_rd_data;
        end
        csaa_pkg::CAPTURE_COORDINATE_CMD:
        begin
          ram_we    = 1'b1;
          ram_wdata = actual_pos;
          nv_we     = nv_persist_en;
          nv_wdata  = actual_pos;
        end
        csaa_pkg::ACCU_TO_COORDINATE_CMD:
        begin
          ram_we    = 1'b1;
          ram_wdata = accu_r;
          nv_we     = nv_persist_en;
          nv_wdata  = accu_r;
        end
        default: ram_we = 1'b0;
      endcase
    // Entry zero stays volatile whatever the path
    if (nv_widx == '0)
      nv_we = 1'b0;
  end

  // Coordinate array, one generate entry per coordinate
  genvar gi;
  generate
    for (gi = 0; gi <= NUM_COORD; gi++)
    begin : g_coord
      always_ff @(posedge ref_clk)
      begin
        if (reset)
          coord_r[gi] <= csaa_pkg::COORD_RST;
        else if (ce && ram_we && ram_widx == IW'(gi))
          coord_r[gi] <= ram_wdata;
      end
    end
  endgenerate

  //--------------------------------------------------------------------
  // Accumulator and X register
  //--------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      accu_r <= csaa_pkg::ACCU_RST;
      x_r    <= csaa_pkg::X_RST;
    end
    else if (ce && exec_ok)
    begin
      // Direct reads leave the accumulator alone so host polling is harmless
      if (cmd_r.instr == csaa_pkg::GET_COORDINATE_CMD && !is_nv && !direct_r)
        accu_r <= rd_coord;
      if (cmd_r.instr == csaa_pkg::X_REGISTER_CALC_CMD)
      begin
        accu_r <= alu_accu;
        x_r    <= alu_x;
      end
    end
  end

  //--------------------------------------------------------------------
  // Sequencer
  //--------------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      csaa_pkg::ST_BOOT:
        state_nxt = nv_persist_en ? csaa_pkg::ST_BULK : csaa_pkg::ST_IDLE;
      csaa_pkg::ST_IDLE:
        if (cmd_valid)
          state_nxt = csaa_pkg::ST_EXEC;
      csaa_pkg::ST_EXEC:
        if (bulk_go)
          state_nxt = csaa_pkg::ST_BULK;
        else
          state_nxt = direct_r ? csaa_pkg::ST_REPLY : csaa_pkg::ST_IDLE;
      csaa_pkg::ST_BULK:
        if (bulk_idx_r == LAST_IDX)
          state_nxt = (direct_r && !boot_r) ? csaa_pkg::ST_REPLY : csaa_pkg::ST_IDLE;
      csaa_pkg::ST_REPLY:
        if (rsp_ready)
          state_nxt = csaa_pkg::ST_IDLE;
      default: state_nxt = csaa_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      state_r <= csaa_pkg::ST_BOOT;
    else if (ce)
      state_r <= state_nxt;
  end

  // Command latch
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cmd_r    <= '0;
      direct_r <= 1'b0;
    end
    else if (ce && cmd_ready && cmd_valid)
    begin
      cmd_r    <= cmd;
      direct_r <= cmd_direct;
    end
  end

  // Bulk walk over entries 1..NUM_COORD, one per cycle
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      bulk_idx_r  <= FIRST_IDX;
      bulk_load_r <= 1'b1;
      boot_r      <= 1'b1;
    end
    else if (ce)
    begin
      if (state_r == csaa_pkg::ST_IDLE)
        boot_r <= 1'b0;
      if (state_r == csaa_pkg::ST_BOOT || bulk_go)
      begin
        bulk_idx_r  <= FIRST_IDX;
        bulk_load_r <= state_r == csaa_pkg::ST_BOOT
                    || cmd_r.instr == csaa_pkg::GET_COORDINATE_CMD;
      end
      else if (state_r == csaa_pkg::ST_BULK)
        bulk_idx_r <= bulk_idx_r + FIRST_IDX;
    end
  end

  // Reply word, built as the command executes
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      rsp_r <= '0;
    else if (ce && state_r == csaa_pkg::ST_EXEC)
    begin
      rsp_r.status <= status_c;
      rsp_r.instr  <= cmd_r.instr;
      rsp_r.value  <= 32'h0000_0000;
      if (exec_ok && cmd_r.instr == csaa_pkg::GET_COORDINATE_CMD)
        rsp_r.value <= (is_nv && !bulk_go) ? nv_rd_data : rd_coord;
      else if (exec_ok && cmd_r.instr == csaa_pkg::CAPTURE_COORDINATE_CMD)
        rsp_r.value <= actual_pos;
    end
  end

  assign cmd_ready = state_r == csaa_pkg::ST_IDLE;
  assign rsp_valid = state_r == csaa_pkg::ST_REPLY;
  assign rsp       = rsp_r;
  assign accu      = accu_r;
  assign x_reg     = x_r;

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_exec_op(logic [7:0] op, logic dir);
    ce && exec_ok && !is_nv && cmd_r.instr == op && direct_r == dir;
  endsequence

  sequence s_reply_ok;
    rsp_valid && rsp.status == csaa_pkg::STAT_OK;
  endsequence

  a_gco_accu_load: assert property (
    s_exec_op(csaa_pkg::GET_COORDINATE_CMD, 1'b0) |=> accu_r == $past(rd_coord))
    else $error("program get-coordinate did not load accumulator");

  a_gco_direct_reply: assert property (
    s_exec_op(csaa_pkg::GET_COORDINATE_CMD, 1'b1)
      |=> s_reply_ok and rsp.value == $past(rd_coord) and accu_r == $past(accu_r))
    else $error("direct get-coordinate reply wrong or accumulator changed");

  a_boot_ram_only: assert property (
    (ce && state_r == csaa_pkg::ST_BOOT && !nv_persist_en) |=> state_r == csaa_pkg::ST_IDLE)
    else $error("startup reload ran with persistence off");

  a_entry0_volatile: assert property (
    nv_we |-> nv_widx != '0)
    else $error("entry zero written to backing store");

  a_bulk_walk: assert property (
    (ce && bulk_go) |=> state_r == csaa_pkg::ST_BULK && bulk_idx_r == FIRST_IDX)
    else $error("bulk copy did not start at entry one");

  a_single_reload: assert property (
    (ce && exec_ok && is_nv && !bulk_go && cmd_r.instr == csaa_pkg::GET_COORDINATE_CMD)
      |=> coord_r[$past(coord_idx)] == $past(nv_rd_data))
    else $error("single reload did not copy entry");

  a_capture_pos: assert property (
    s_exec_op(csaa_pkg::CAPTURE_COORDINATE_CMD, 1'b1)
      |=> s_reply_ok and coord_r[$past(coord_idx)] == $past(actual_pos)
          and rsp.value == $past(actual_pos))
    else $error("capture did not store position");

  a_aco_write: assert property (
    (ce && exec_ok && cmd_r.instr == csaa_pkg::ACCU_TO_COORDINATE_CMD)
      |=> coord_r[$past(coord_idx)] == $past(accu_r))
    else $error("accumulator not copied to entry");

  a_calc_swap: assert property (
    (ce && exec_ok && cmd_r.instr == csaa_pkg::X_REGISTER_CALC_CMD
      && cmd_r.typ == 8'(csaa_pkg::CALC_SWAP))
      |=> accu_r == $past(x_r) && x_r == $past(accu_r))
    else $error("swap did not exchange registers");

endmodule : csaa_core
`default_nettype wire

// ==== testbench/csaa_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host controller: offers one command frame at a time, takes the reply
module csaa_host_model (
  input  wire logic                ref_clk,
  input  wire logic                cmd_ready,
  input  wire logic                rsp_valid,
  input  wire csaa_pkg::csaa_rsp_t rsp,
  output var logic                 cmd_valid = 1'b0,
  output var logic                 cmd_direct = 1'b0,
  output var csaa_pkg::csaa_cmd_t  cmd = '0,
  output var logic                 rsp_ready = 1'b0
);
  int stall = 0; // Cycles of reply back-pressure

  // Bounded wait so a dead block cannot hang the host
  task automatic wait_hi(input logic which);
    int n;
    n = 0;
    while ((which ? rsp_valid : cmd_ready) !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk) #1;
      n++;
    end
  endtask : wait_hi

  task automatic send(input logic [7:0] ins, typ, mot, input logic [31:0] val,
                      input logic dir, output csaa_pkg::csaa_rsp_t r);
    csaa_pkg::csaa_cmd_t f;
    r = '0;
    // Frame built aside so the bus changes once per step
    f = '{8'h01, ins, typ, mot, val, 8'h00};
    f.csum = 8'h01 + ins + typ + mot + val[31:24] + val[23:16] + val[15:8] + val[7:0];
    wait_hi(1'b0);
    cmd = f;
    cmd_direct = dir;
    cmd_valid = 1'b1;
    @(posedge ref_clk) #1;
    cmd_valid = 1'b0;
    cmd = ~cmd; // Released frame shows no stale value
    if (dir)
    begin
      wait_hi(1'b1);
      repeat (stall) @(posedge ref_clk) #1;
      rsp_ready = 1'b1;
      @(posedge ref_clk);
      r = rsp;
      #1 rsp_ready = 1'b0;
    end
    wait_hi(1'b0); // Program mode: let the command finish
  endtask : send
endmodule : csaa_host_model
`default_nettype wire

// ==== testbench/tb_csaa_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_csaa_core;
  logic                ref_clk = 1'b0;
  logic                reset = 1'b1;
  logic                ce = 1'b1;
  logic [31:0]         actual_pos = 32'h0000_0000;
  logic                nv_persist_en = 1'b0;
  logic                cmd_valid, cmd_ready, cmd_direct, rsp_valid, rsp_ready;
  csaa_pkg::csaa_cmd_t cmd;
  csaa_pkg::csaa_rsp_t rsp, r;
  logic [31:0]         accu, x_reg;
  int                  num_errors = 0;
  int                  checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  csaa_core #(.NUM_COORD(20)) i_dut (.ref_clk(ref_clk), .reset(reset), .ce(ce),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_direct(cmd_direct), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .actual_pos(actual_pos),
    .nv_persist_en(nv_persist_en), .accu(accu), .x_reg(x_reg));
  csaa_host_model i_host (.ref_clk(ref_clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp(rsp), .cmd_valid(cmd_valid), .cmd_direct(cmd_direct), .cmd(cmd),
    .rsp_ready(rsp_ready));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic do_reset();
    reset = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 reset = 1'b0;
  endtask : do_reset

  task automatic op(input logic [7:0] i, t, m, input logic [31:0] v, input logic d);
    i_host.send(i, t, m, v, d, r);
    if (d)
    begin
      chk("reply status", {24'h0, csaa_pkg::STAT_OK}, {24'h0, r.status});
      chk("reply instr", {24'h0, i}, {24'h0, r.instr});
    end
  endtask : op

  task automatic bad(input logic [7:0] i, t, m, st);
    i_host.send(i, t, m, 32'h0, 1'b1, r);
    chk("error status", {24'h0, st}, {24'h0, r.status});
  endtask : bad

  task automatic set_coordinate_cmd(input logic [7:0] t, m, input logic [31:0] v);
    op(csaa_pkg::SET_COORDINATE_CMD, t, m, v, 1'b1);
  endtask : set_coordinate_cmd

  task automatic get_coordinate_cmd(input logic [7:0] t, m, input logic d);
    op(csaa_pkg::GET_COORDINATE_CMD, t, m, 32'h0, d);
  endtask : get_coordinate_cmd

  // Store, read back direct and from a program, top entry negative
  task automatic t_set_get();
    chk("accu after reset", 32'h0, accu);
    chk("x after reset", 32'h0, x_reg);
    set_coordinate_cmd(8'h01, 8'h00, 32'h0000_03e8);
    set_coordinate_cmd(8'h14, 8'h00, 32'h8000_0001);
    get_coordinate_cmd(8'h01, 8'h00, 1'b1);
    chk("get value", 32'h0000_03e8, r.value);
    chk("accu kept", 32'h0, accu);
    get_coordinate_cmd(8'h14, 8'h00, 1'b1);
    chk("get top entry", 32'h8000_0001, r.value);
    get_coordinate_cmd(8'h01, 8'h00, 1'b0);
    chk("program get", 32'h0000_03e8, accu);
    $display("test set_get done");
  endtask : t_set_get

  // Capture with a slow host, then accumulator to entry
  task automatic t_capture();
    actual_pos = 32'h1234_5678;
    i_host.stall = 3;
    op(csaa_pkg::CAPTURE_COORDINATE_CMD, 8'h03, 8'h00, 32'h0, 1'b1);
    i_host.stall = 0;
    chk("capture reply", 32'h1234_5678, r.value);
    get_coordinate_cmd(8'h03, 8'h00, 1'b1);
    chk("captured entry", 32'h1234_5678, r.value);
    op(csaa_pkg::ACCU_TO_COORDINATE_CMD, 8'h02, 8'h00, 32'h0, 1'b1);
    get_coordinate_cmd(8'h02, 8'h00, 1'b1);
    chk("accu entry", 32'h0000_03e8, r.value);
    $display("test capture done");
  endtask : t_capture

  // Every X register operation from fresh operands
  task automatic t_calc();
    logic [31:0] a, x, ea, ex;
    a = 32'h0000_03e8;
    x = 32'h0000_0007;
    for (int k = 0; k <= 10; k++)
    begin
      set_coordinate_cmd(8'h04, 8'h00, x);
      get_coordinate_cmd(8'h04, 8'h00, 1'b0);
      op(csaa_pkg::X_REGISTER_CALC_CMD, 8'h09, 8'h00, 32'h0, 1'b0);
      set_coordinate_cmd(8'h04, 8'h00, a);
      get_coordinate_cmd(8'h04, 8'h00, 1'b0);
      ea = a;
      ex = x;
      case (k)
        0: ea = a + x;
        1: ea = a - x;
        2: ea = a * x;
        3: ea = a / x;
        4: ea = a % x;
        5: ea = a & x;
        6: ea = a | x;
        7: ea = a ^ x;
        8: ex = ~x;
        9: ex = a;
        default:
        begin
          ea = x;
          ex = a;
        end
      endcase
      op(csaa_pkg::X_REGISTER_CALC_CMD, 8'(k), 8'h00, 32'h0, 1'b1);
      chk("calc accu", ea, accu);
      chk("calc x", ex, x_reg);
    end
    $display("test calc done");
  endtask : t_calc

  // Refused commands change nothing; a frozen clock enable only stretches a command
  task automatic t_errors();
    bad(8'h1c, 8'h00, 8'h00, csaa_pkg::STAT_BAD_CMD);
    bad(csaa_pkg::X_REGISTER_CALC_CMD, 8'h0b, 8'h00, csaa_pkg::STAT_BAD_TYPE);
    bad(csaa_pkg::GET_COORDINATE_CMD, 8'h15, 8'h00, csaa_pkg::STAT_BAD_VALUE);
    set_coordinate_cmd(8'h04, 8'h00, 32'h0);
    get_coordinate_cmd(8'h04, 8'h00, 1'b0);
    op(csaa_pkg::X_REGISTER_CALC_CMD, 8'h09, 8'h00, 32'h0, 1'b0);
    get_coordinate_cmd(8'h01, 8'h00, 1'b0);
    bad(csaa_pkg::X_REGISTER_CALC_CMD, 8'h03, 8'h00, csaa_pkg::STAT_BAD_VALUE);
    chk("div zero accu", 32'h0000_03e8, accu);
    fork
      op(csaa_pkg::X_REGISTER_CALC_CMD, 8'h09, 8'h00, 32'h0, 1'b1);
      begin
        @(posedge ref_clk) #1;
        ce = 1'b0;
        @(posedge ref_clk) #1;
        chk("ce freeze", 32'h0, {31'h0, rsp_valid});
        repeat (3) @(posedge ref_clk) #1;
        ce = 1'b1;
      end
    join
    chk("load after freeze", 32'h0000_03e8, x_reg);
    $display("test errors done");
  endtask : t_errors

  // Save and reload, single and bulk, then startup reload
  task automatic t_nv();
    set_coordinate_cmd(8'h05, 8'h00, 32'h0000_0aaa);
    set_coordinate_cmd(8'h05, 8'hff, 32'h0);
    set_coordinate_cmd(8'h05, 8'h00, 32'h0000_0bbb);
    get_coordinate_cmd(8'h05, 8'hff, 1'b1);
    chk("single reload", 32'h0000_0aaa, r.value);
    set_coordinate_cmd(8'h00, 8'h00, 32'h0000_0d0d);
    set_coordinate_cmd(8'h06, 8'h00, 32'h0000_0c0c);
    set_coordinate_cmd(8'h00, 8'hff, 32'h0);
    set_coordinate_cmd(8'h06, 8'h00, 32'h0000_0e0e);
    set_coordinate_cmd(8'h00, 8'h00, 32'h0000_0f0f);
    get_coordinate_cmd(8'h00, 8'hff, 1'b1);
    get_coordinate_cmd(8'h06, 8'h00, 1'b1);
    chk("bulk reload", 32'h0000_0c0c, r.value);
    get_coordinate_cmd(8'h00, 8'h00, 1'b1);
    chk("entry zero kept", 32'h0000_0f0f, r.value);
    nv_persist_en = 1'b1;
    set_coordinate_cmd(8'h07, 8'h00, 32'h0000_7777);
    do_reset();
    get_coordinate_cmd(8'h07, 8'h00, 1'b1);
    chk("startup reload", 32'h0000_7777, r.value);
    get_coordinate_cmd(8'h00, 8'h00, 1'b1);
    chk("entry zero volatile", 32'h0, r.value);
    $display("test nv done");
  endtask : t_nv

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  initial
  begin
    do_reset();
    t_set_get();
    t_capture();
    t_calc();
    t_errors();
    t_nv();
    final_report();
  end

  // Whole run needs a few hundred cycles
  initial
  begin
    #100000;
    num_errors++;
    final_report();
  end
endmodule : tb_csaa_core
`default_nettype wire
